// file: logic/wbs_sequencer.sv
// Burst word address sequencer: linear, legacy wrap and hybrid bursts.
// Configuration lives on clk; the address logic runs on the host's
// link clock, which may stop between bursts.
`timescale 1ns/10ps
`default_nettype none
`include "wbs_map.svh"

module wbs_sequencer
  import wbs_pkg::*;
#(
  parameter int ADDR_W = 32
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cfg_write,
  input wire logic [1:0] cfg_wrap_length_field,
  input wire logic cfg_burst_sequence_select,
  output logic [1:0] wrap_length_field,
  output logic burst_sequence_select,
  output logic burst_busy,
  output logic wrap_done_pulse,
  input wire logic link_clk,
  input wire logic cs_n,
  input wire logic ca_valid,
  input wire logic [ADDR_W-1:0] ca_word_addr,
  input wire logic burst_type_bit,
  input wire logic word_advance,
  output logic [ADDR_W-1:0] word_addr,
  output logic word_addr_valid,
  output logic in_linear
);

  // Elaboration check: a 128-byte group needs ADDR_W of at least eight bits
  generate
    if (ADDR_W < `WBS_MASK_W + 1) begin : g_bad_width
      $error("wbs_sequencer: ADDR_W too small for a 128-byte group");
    end
  endgenerate

  // ---------------- clk domain: configuration and status ----------------

  logic [1:0] next_wrap_length_field;
  logic next_burst_sequence_select;
  logic busy_sync;
  logic done_tog_sync;
  logic done_tog_seen;
  logic next_done_tog_seen;
  logic next_wrap_done_pulse;

  // Configuration bits load on cfg_write, reset to 32-byte legacy wrap
  always_comb begin
    next_wrap_length_field = wrap_length_field;
    next_burst_sequence_select = burst_sequence_select;
    if (cfg_write) begin
      next_wrap_length_field = cfg_wrap_length_field;
      next_burst_sequence_select = cfg_burst_sequence_select;
    end
    next_done_tog_seen = done_tog_sync;
    next_wrap_done_pulse = done_tog_sync ^ done_tog_seen;
  end

  // Configuration and status registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wrap_length_field <= `WBS_LEN_RST;
      burst_sequence_select <= `WBS_SEL_RST;
      done_tog_seen <= 1'h0;
      wrap_done_pulse <= 1'h0;
      burst_busy <= 1'h0;
    end else begin
      wrap_length_field <= next_wrap_length_field;
      burst_sequence_select <= next_burst_sequence_select;
      done_tog_seen <= next_done_tog_seen;
      wrap_done_pulse <= next_wrap_done_pulse;
      burst_busy <= busy_sync;
    end
  end

  // ---------------- crossings ----------------

  logic link_rst;
  logic [1:0] link_len;
  logic link_sel;
  logic busy_link;
  logic done_tog;

  // Reset into the link domain
  wbs_sync #(.WIDTH(1)) u_rst_sync (
    .dst_clk(link_clk),
    .src_level(sys_rst),
    .dst_level(link_rst)
  );

  // Quasi-static configuration into the link domain
  wbs_sync #(.WIDTH(3)) u_cfg_sync (
    .dst_clk(link_clk),
    .src_level({wrap_length_field, burst_sequence_select}),
    .dst_level({link_len, link_sel})
  );

  // Busy level and wrap-done toggle back to clk
  wbs_sync #(.WIDTH(2)) u_stat_sync (
    .dst_clk(clk),
    .src_level({busy_link, done_tog}),
    .dst_level({busy_sync, done_tog_sync})
  );

  // ---------------- link domain: address sequencing ----------------

  wbs_state_t state;
  wbs_state_t next_state;
  wbs_kind_t kind;
  wbs_kind_t next_kind;
  logic [ADDR_W-1:0] start_addr;
  logic [ADDR_W-1:0] next_start_addr;
  logic [ADDR_W-1:0] next_word_addr;
  logic [`WBS_MASK_W-1:0] mask;
  logic [`WBS_MASK_W-1:0] next_mask;
  logic next_done_tog;
  logic [ADDR_W-1:0] grp_next;
  logic [ADDR_W-1:0] lin_next;
  logic [ADDR_W-1:0] next_group_base;
  logic wrap_end;
  logic start_req;
  logic step;
  logic next_busy_link;

  // Address arithmetic for the current word
  wbs_next_addr #(.ADDR_W(ADDR_W)) u_next (
    .cur_addr(word_addr),
    .start_addr(start_addr),
    .mask(mask),
    .grp_next(grp_next),
    .lin_next(lin_next),
    .next_group_base(next_group_base),
    .wrap_end(wrap_end)
  );

  assign start_req = ca_valid && !cs_n;
  assign step = word_advance && !cs_n && !ca_valid && (state != WBS_IDLE);

  // Frame signal ends the burst even if the link clock stops
  assign word_addr_valid = (state != WBS_IDLE) && !cs_n;

  // Next state, kind and address of the burst
  always_comb begin
    next_state = state;
    next_kind = kind;
    next_start_addr = start_addr;
    next_word_addr = word_addr;
    next_mask = mask;
    next_done_tog = done_tog;
    if (cs_n) begin
      next_state = WBS_IDLE;
    end else if (start_req) begin
      next_start_addr = ca_word_addr;
      next_word_addr = ca_word_addr;
      next_mask = wbs_group_mask(link_len);
      if (burst_type_bit != `WBS_TYPE_WRAP) begin
        next_kind = WBS_KIND_LINEAR;
        next_state = WBS_LINEAR;
      end else if (link_sel == `WBS_SEL_HYBRID) begin
        next_kind = WBS_KIND_HYBRID;
        next_state = WBS_WRAP;
      end else begin
        next_kind = WBS_KIND_LEGACY;
        next_state = WBS_WRAP;
      end
    end else if (step) begin
      unique case (state)
        WBS_WRAP: begin
          if (kind == WBS_KIND_HYBRID && wrap_end) begin
            next_word_addr = next_group_base;
            next_state = WBS_LINEAR;
            next_done_tog = !done_tog;
          end else begin
            next_word_addr = grp_next;
          end
        end
        WBS_LINEAR: begin
          next_word_addr = lin_next;
        end
        default: begin
          next_state = WBS_IDLE;
        end
      endcase
    end
    next_busy_link = (next_state != WBS_IDLE); // Registered so no decode glitch crosses
  end

  // Link-domain registers
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      state <= WBS_IDLE;
      kind <= WBS_KIND_LINEAR;
      start_addr <= '0;
      word_addr <= '0;
      mask <= `WBS_MASK_32;
      done_tog <= 1'h0;
      busy_link <= 1'h0;
    end else begin
      state <= next_state;
      kind <= next_kind;
      start_addr <= next_start_addr;
      word_addr <= next_word_addr;
      mask <= next_mask;
      done_tog <= next_done_tog;
      busy_link <= next_busy_link;
    end
  end

  assign in_linear = (state == WBS_LINEAR);

  // ---------------- checks on the link domain ----------------

  default clocking cb_link @(posedge link_clk);
  endclocking
  default disable iff (link_rst);

  logic [ADDR_W-1:0] group_of_start;
  assign group_of_start = start_addr & ~ADDR_W'(mask);

  sequence s_wrap_last;
    (state == WBS_WRAP) && (kind == WBS_KIND_HYBRID) && step && wrap_end;
  endsequence

  sequence s_start_wrap;
    start_req && (burst_type_bit == `WBS_TYPE_WRAP);
  endsequence

  chk_wrap_in_group: assert property (
    (state == WBS_WRAP) |-> ((word_addr & ~ADDR_W'(mask)) == group_of_start))
    else $error("wrap left its aligned group");

  chk_mask_legal: assert property (
    (state != WBS_IDLE) |-> (mask inside {`WBS_MASK_16, `WBS_MASK_32, `WBS_MASK_64,
      `WBS_MASK_128}))
    else $error("group length not one of the four supported");

  chk_first_word: assert property (
    start_req |=> (word_addr == $past(ca_word_addr)) && (start_addr == word_addr))
    else $error("burst did not begin at the requested word");

  chk_hybrid_exit: assert property (
    s_wrap_last |=> (state == WBS_LINEAR))
    else $error("hybrid burst did not leave the group after one wrap");

  chk_hybrid_next_group: assert property (
    s_wrap_last ##1 !cs_n |-> (word_addr == $past(start_addr | ADDR_W'(mask)) + ADDR_W'(1)))
    else $error("hybrid linear part not at next group base");

  chk_linear_run: assert property (
    (state == WBS_LINEAR) && step |=> (state == WBS_LINEAR) && (word_addr == $past(lin_next)))
    else $error("linear advance stopped before chip select rose");

  chk_select_hybrid: assert property (
    (s_start_wrap and (link_sel == `WBS_SEL_HYBRID)) |=> (kind == WBS_KIND_HYBRID))
    else $error("select 0 did not give a hybrid burst");

  chk_select_legacy: assert property (
    (state == WBS_WRAP) && (kind == WBS_KIND_LEGACY) && step |=> (state == WBS_WRAP))
    else $error("legacy wrap stopped repeating");

  chk_word_step: assert property (
    (state == WBS_WRAP) && step && !wrap_end && ((word_addr & ADDR_W'(mask)) !=
      ADDR_W'(mask)) |=> (word_addr == $past(word_addr) + ADDR_W'(1)))
    else $error("in-group step is not one word");

  chk_len_decode: assert property (
    start_req && (link_len == `WBS_LEN_16) |=> (mask == `WBS_MASK_16))
    else $error("16-byte code not decoded to eight words");

  chk_type_ignores: assert property (
    start_req && (burst_type_bit != `WBS_TYPE_WRAP) |=> (kind == WBS_KIND_LINEAR)
      && (state == WBS_LINEAR))
    else $error("select bit honoured on a linear request");

  chk_linear_step: assert property (
    (kind == WBS_KIND_LINEAR) && (state == WBS_LINEAR) && step |=>
      (word_addr == $past(word_addr) + ADDR_W'(1)))
    else $error("linear burst did not add one word");

  chk_cs_ends: assert property (
    cs_n |=> (state == WBS_IDLE) && !word_addr_valid)
    else $error("burst survived chip select high");

  chk_legacy_restart: assert property (
    (state == WBS_WRAP) && (kind == WBS_KIND_LEGACY) && step && wrap_end |=> (word_addr == start_addr))
    else $error("legacy wrap did not return to the start word");

  chk_group_top_wraps: assert property (
    (state == WBS_WRAP) && step && !wrap_end && ((word_addr & ADDR_W'(mask)) == ADDR_W'(mask))
      |=> (word_addr == group_of_start))
    else $error("group end did not wrap to the group base");

  chk_done_toggle: assert property (
    s_wrap_last |=> (done_tog != $past(done_tog)))
    else $error("wrap completion not signalled");

  chk_busy_follows: assert property (
    cs_n |=> !busy_link)
    else $error("busy stayed high after chip select rose");

endmodule

`default_nettype wire

// file: logic/wbs_map.svh
// Constants for the wrap/hybrid burst sequencer: field encodings,
// reset values and group masks.
// Assumes inclusion by the package, the sequencer and the next-address module.
`ifndef WBS_MAP_SVH
`define WBS_MAP_SVH

// Wrap length field codes
`define WBS_LEN_128 2'h0
`define WBS_LEN_64 2'h1
`define WBS_LEN_16 2'h2
`define WBS_LEN_32 2'h3

// Word masks of each group (bytes / 2 - 1)
`define WBS_MASK_128 7'h3F
`define WBS_MASK_64 7'h1F
`define WBS_MASK_16 7'h07
`define WBS_MASK_32 7'h0F
`define WBS_MASK_W 7

// Reset values of the configuration bits
`define WBS_LEN_RST 2'h3
`define WBS_SEL_RST 1'h1

// Select and burst type encodings
`define WBS_SEL_HYBRID 1'h0
`define WBS_TYPE_WRAP 1'h0

`endif

// file: logic/wbs_pkg.sv
// Types and decode helpers of the wrap/hybrid burst sequencer.
// Assumes wbs_map.svh on the include path.
`default_nettype none
`include "wbs_map.svh"

package wbs_pkg;

  typedef enum logic [1:0] {WBS_IDLE, WBS_WRAP, WBS_LINEAR} wbs_state_t;

  typedef enum logic [1:0] {WBS_KIND_LINEAR, WBS_KIND_LEGACY, WBS_KIND_HYBRID} wbs_kind_t;

  // Word mask of the group selected by the length field
  function automatic logic [`WBS_MASK_W-1:0] wbs_group_mask(input logic [1:0] len);
    logic [`WBS_MASK_W-1:0] m;
    m = `WBS_MASK_32;
    unique case (len)
      `WBS_LEN_128: m = `WBS_MASK_128;
      `WBS_LEN_64: m = `WBS_MASK_64;
      `WBS_LEN_16: m = `WBS_MASK_16;
      `WBS_LEN_32: m = `WBS_MASK_32;
    endcase
    return m;
  endfunction

endpackage

`default_nettype wire

// file: logic/wbs_sync.sv
// Two-flop synchroniser for levels into the clock of its destination.
// Assumes the source holds each value long enough to be seen.
`timescale 1ns/10ps
`default_nettype none

module wbs_sync
  import wbs_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input wire logic dst_clk,
  input wire logic [WIDTH-1:0] src_level,
  output logic [WIDTH-1:0] dst_level
);

  logic [WIDTH-1:0] meta;

  // First stage feeds only the second
  always_ff @(posedge dst_clk) begin
    meta <= src_level;
    dst_level <= meta;
  end

endmodule

`default_nettype wire

// file: logic/wbs_next_addr.sv
// Next word address of a burst: in-group increment or plain increment,
// with detection of the end of one full wrap.
// Assumes a mask of all ones in the low bits.
`timescale 1ns/10ps
`default_nettype none
`include "wbs_map.svh"

module wbs_next_addr
  import wbs_pkg::*;
#(
  parameter int ADDR_W = 32
) (
  input wire logic [ADDR_W-1:0] cur_addr,
  input wire logic [ADDR_W-1:0] start_addr,
  input wire logic [`WBS_MASK_W-1:0] mask,
  output logic [ADDR_W-1:0] grp_next,
  output logic [ADDR_W-1:0] lin_next,
  output logic [ADDR_W-1:0] next_group_base,
  output logic wrap_end
);

  logic [ADDR_W-1:0] wide_mask;
  logic [ADDR_W-1:0] lin_sum;

  // Increment inside the aligned group, wrap at its end
  always_comb begin
    wide_mask = ADDR_W'(mask);
    lin_sum = cur_addr + ADDR_W'(1);
    lin_next = lin_sum;
    grp_next = (cur_addr & ~wide_mask) | (lin_sum & wide_mask);
    wrap_end = (grp_next == start_addr);
    next_group_base = (start_addr & ~wide_mask) + wide_mask + ADDR_W'(1);
  end

endmodule

`default_nettype wire

// file: bench/wbs_host_model.sv
// Host controller model: opens a frame, issues a start word and type,
// consumes a given number of words, then closes the frame.
// Assumes the bench holds req until done answers, and free_run during reset.
`timescale 1ns/10ps
`default_nettype none

module wbs_host_model
  import wbs_pkg::*;
#(
  parameter int ADDR_W = 32
) (
  input wire logic free_run,
  input wire logic req,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic req_type,
  input wire logic [15:0] req_words,
  output logic done,
  output logic link_clk,
  output logic cs_n,
  output logic ca_valid,
  output logic [ADDR_W-1:0] ca_word_addr,
  output logic burst_type_bit,
  output logic word_advance
);
  logic in_frame;

  // Link clock runs in frames or during reset, parks low otherwise
  initial begin
    link_clk = 1'b0;
    forever begin
      #24;
      if (free_run || in_frame || link_clk) begin
        link_clk = ~link_clk;
      end
    end
  end

  // One frame per request
  initial begin
    in_frame = 1'b0;
    done = 1'b0;
    cs_n = 1'b1;
    ca_valid = 1'b0;
    ca_word_addr = '0;
    burst_type_bit = 1'b1;
    word_advance = 1'b0;
    forever begin
      wait (req === 1'b1);
      in_frame = 1'b1;
      repeat (4) @(posedge link_clk);
      cs_n <= 1'b0;
      @(posedge link_clk);
      ca_valid <= 1'b1;
      ca_word_addr <= req_addr;
      burst_type_bit <= req_type;
      @(posedge link_clk);
      // Address and type only stand for the start edge
      ca_valid <= 1'b0;
      ca_word_addr <= ~req_addr;
      burst_type_bit <= ~req_type;
      for (int i = 1; i < req_words; i++) begin
        word_advance <= 1'b1;
        @(posedge link_clk);
      end
      word_advance <= 1'b0;
      @(posedge link_clk);
      cs_n <= 1'b1;
      repeat (3) @(posedge link_clk);
      in_frame = 1'b0;
      done = 1'b1;
      wait (req === 1'b0);
      done = 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: bench/testbench.sv
// Self-checking bench of the burst sequencer against a host model.
// Assumes the design files and wbs_host_model are compiled first.
`timescale 1ns/10ps
`default_nettype none

module testbench
  import wbs_pkg::*;
;
  typedef struct {
    logic [1:0] len;
    logic sel;
    logic typ;
    logic [31:0] start;
    int words;
  } wbs_row_t;
  localparam int LIMIT = 20000;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cfg_write = 1'b0;
  logic [1:0] cfg_len = 2'h0;
  logic cfg_sel = 1'h0;
  logic free_run = 1'b1;
  logic req = 1'b0;
  logic [31:0] req_addr = 32'h0;
  logic req_type = 1'b0;
  logic [15:0] req_words = 16'h0;
  logic done, link_clk, cs_n, ca_valid, burst_type_bit, word_advance;
  logic [31:0] ca_word_addr, word_addr;
  logic [1:0] wrap_length_field;
  logic burst_sequence_select, burst_busy, wrap_done_pulse, word_addr_valid, in_linear;
  logic [31:0] got_a[$];
  logic got_l[$];
  int bad_count = 0;
  int num_checks = 0;
  int pulses, busy_seen, cycles = 0;
  wbs_row_t rows [12];

  wbs_sequencer u_dut (.clk(clk), .sys_rst(sys_rst), .cfg_write(cfg_write),
    .cfg_wrap_length_field(cfg_len), .cfg_burst_sequence_select(cfg_sel),
    .wrap_length_field(wrap_length_field), .burst_sequence_select(burst_sequence_select),
    .burst_busy(burst_busy), .wrap_done_pulse(wrap_done_pulse), .link_clk(link_clk),
    .cs_n(cs_n), .ca_valid(ca_valid), .ca_word_addr(ca_word_addr),
    .burst_type_bit(burst_type_bit), .word_advance(word_advance), .word_addr(word_addr),
    .word_addr_valid(word_addr_valid), .in_linear(in_linear));

  wbs_host_model u_host (.free_run(free_run), .req(req), .req_addr(req_addr),
    .req_type(req_type), .req_words(req_words), .done(done), .link_clk(link_clk),
    .cs_n(cs_n), .ca_valid(ca_valid), .ca_word_addr(ca_word_addr),
    .burst_type_bit(burst_type_bit), .word_advance(word_advance));

  // System clock, 50 ns
  initial begin
    forever #25 clk = ~clk;
  end

  // Capture each presented word, count pulses and busy cycles, cut hangs
  always @(negedge link_clk) begin
    if (word_addr_valid === 1'b1) begin
      got_a.push_back(word_addr);
      got_l.push_back(in_linear);
    end
  end
  always @(posedge clk) begin
    if (wrap_done_pulse === 1'b1) pulses++;
    if (burst_busy === 1'b1) busy_seen++;
    cycles++;
    if (cycles == LIMIT) begin
      bad_count++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic ok, input string what);
    num_checks++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("FAIL %0t %s", $time, what);
    end
  endtask

  // Expected word at index i, worked out from group size and mode
  function automatic logic [31:0] exp_addr(input wbs_row_t r, input int i, output logic lin);
    logic [31:0] m, base;
    case (r.len)
      2'h0: m = 32'h0000003F;
      2'h1: m = 32'h0000001F;
      2'h2: m = 32'h00000007;
      default: m = 32'h0000000F;
    endcase
    base = r.start & ~m;
    lin = (r.typ == 1'b0) && (r.sel == 1'b0) && (i > m);
    if (r.typ == 1'b1) return r.start + i;
    if (lin) return base + i;
    return base | ((r.start + i) & m);
  endfunction

  task automatic run_row(input wbs_row_t r, input logic wr);
    logic [31:0] e;
    logic lin;
    int n;
    @(posedge clk);
    cfg_write <= wr;
    cfg_len <= r.len;
    cfg_sel <= r.sel;
    @(posedge clk);
    cfg_write <= 1'b0;
    got_a.delete();
    got_l.delete();
    pulses = 0;
    busy_seen = 0;
    req_addr <= r.start;
    req_type <= r.typ;
    req_words <= 16'(r.words);
    req <= 1'b1;
    n = 0;
    while (done !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    req <= 1'b0;
    repeat (10) @(posedge clk);
    chk(got_a.size() == r.words, "word count");
    for (int i = 0; i < got_a.size() && i < r.words; i++) begin
      e = exp_addr(r, i, lin);
      chk(got_a[i] === e, "word address");
      chk(got_l[i] === (lin | r.typ), "linear flag");
    end
    e = exp_addr(r, r.words - 1, lin);
    chk(pulses == (lin ? 1 : 0), "wrap done pulse");
    chk(busy_seen > 0, "busy seen");
    chk(wrap_length_field === r.len && burst_sequence_select === r.sel, "config fields");
  endtask

  task automatic do_reset(input int hold);
    free_run <= 1'b1;
    sys_rst <= 1'b1;
    repeat (hold) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (6) @(posedge clk);
    free_run <= 1'b0;
    @(posedge clk);
    chk(wrap_length_field === 2'h3, "length reset");
    chk(burst_sequence_select === 1'b1, "select reset");
    chk(word_addr_valid === 1'b0 && in_linear === 1'b0, "link reset");
    chk(burst_busy === 1'b0 && wrap_done_pulse === 1'b0, "status reset");
    $display("reset check done");
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Main sequence: reset, table rows, then mid-run reset and default burst
  initial begin
    rows = '{'{2'h0, 1'h0, 1'h0, 32'h00000003, 68}, '{2'h1, 1'h0, 1'h0, 32'h1234562E, 36},
      '{2'h2, 1'h0, 1'h0, 32'h0000000C, 12}, '{2'h3, 1'h0, 1'h0, 32'h0000000A, 20},
      '{2'h2, 1'h0, 1'h0, 32'h00000040, 9}, '{2'h1, 1'h1, 1'h0, 32'h00000003, 40},
      '{2'h2, 1'h1, 1'h0, 32'h00000002, 20}, '{2'h0, 1'h1, 1'h0, 32'h0000017F, 70},
      '{2'h3, 1'h1, 1'h0, 32'h0000000A, 18}, '{2'h3, 1'h0, 1'h0, 32'h0000001F, 3},
      '{2'h2, 1'h0, 1'h1, 32'h00000003, 22}, '{2'h2, 1'h1, 1'h1, 32'h0000003E, 10}};
    do_reset(2);
    for (int k = 0; k < 12; k++) begin
      run_row(rows[k], 1'b1);
      $display("row %0d done", k);
    end
    run_row('{2'h0, 1'h0, 1'h0, 32'h00000010, 4}, 1'b1);
    do_reset(8);
    run_row('{2'h3, 1'h1, 1'h0, 32'h00000005, 20}, 1'b0);
    $display("reset test done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
